//--- hw/dpr_regs.svh
// Constants for the dual-port memory port logic
`ifndef DPR_REGS_SVH
`define DPR_REGS_SVH

`define DPR_ADDR_W 18
`define DPR_DATA_W 36
`define DPR_LANES 4
`define DPR_LANE_W 9
`define DPR_DEPTH 262144
`define DPR_MBOX_R 18'h3FFFF
`define DPR_MBOX_L 18'h3FFFE
`define DPR_MASK_RST 18'h3FFFF
`define DPR_ADDR_ZERO 18'h00000
`define DPR_COLL_DATA 36'h000000000

`endif

//--- hw/dpr_pkg.sv
// Types shared by the dual-port memory port logic
package dpr_pkg;
	typedef enum logic [5:0] {
		DPR_OP_HOLD = 6'h01,
		DPR_OP_LOAD = 6'h02,
		DPR_OP_MASK = 6'h04,
		DPR_OP_INC = 6'h08,
		DPR_OP_CLR = 6'h10,
		DPR_OP_RDBK = 6'h20
	} dpr_op_t;
endpackage : dpr_pkg

//--- hw/dpr_addr_ctr.sv
// Burst address counter, mask register and address readback for one port
`timescale 1ns/1ns
`include "dpr_regs.svh"
module dpr_addr_ctr (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ads_n,
	input wire logic adv_n,
	input wire logic clr_n,
	input wire logic sel,
	input wire logic [17:0] a_in,
	output logic [17:0] addr_now,
	output logic wrap_irq_n,
	output logic rb_oe,
	output logic [17:0] rb_val
);
	// Counter operation from the strobe levels
	function automatic dpr_pkg::dpr_op_t dpr_decode(input logic s_n, input logic e_n, input logic c_n, input logic m);
		dpr_pkg::dpr_op_t op;
		op = dpr_pkg::DPR_OP_HOLD;
		if (!c_n) begin
			op = dpr_pkg::DPR_OP_CLR;
		end else if (!s_n && !e_n) begin
			op = m ? dpr_pkg::DPR_OP_LOAD : dpr_pkg::DPR_OP_MASK;
		end else if (s_n && !e_n) begin
			op = dpr_pkg::DPR_OP_INC;
		end else if (!s_n && e_n) begin
			op = dpr_pkg::DPR_OP_RDBK;
		end
		return op;
	endfunction : dpr_decode

	logic [17:0] addr_q;
	logic [17:0] mask_q;
	logic [17:0] base_q;
	logic irq_n_q;
	logic rb_oe_q;
	logic [17:0] rb_val_q;
	dpr_pkg::dpr_op_t op;
	logic at_max;
	logic [17:0] step_val;
	logic [17:0] inc_val;
	logic inc_hits_max;

	// Masked increment, wrapping back to the loaded value
	assign op = dpr_decode(ads_n, adv_n, clr_n, sel);
	assign at_max = (addr_q & mask_q) == mask_q;
	assign step_val = (addr_q & ~mask_q) | ((addr_q + 18'h00001) & mask_q);
	assign inc_val = at_max ? ((addr_q & ~mask_q) | (base_q & mask_q)) : step_val;
	assign inc_hits_max = (inc_val & mask_q) == mask_q;

	// Address used by this cycle's access
	assign addr_now = (op == dpr_pkg::DPR_OP_CLR) ? `DPR_ADDR_ZERO :
		(op == dpr_pkg::DPR_OP_LOAD) ? a_in :
		(op == dpr_pkg::DPR_OP_INC) ? inc_val : addr_q;

	// Counter, mask, base and wrap flag
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			addr_q <= `DPR_ADDR_ZERO;
			mask_q <= `DPR_MASK_RST;
			base_q <= `DPR_ADDR_ZERO;
			irq_n_q <= 1'b1;
		end else begin
			addr_q <= addr_now;
			mask_q <= (op == dpr_pkg::DPR_OP_MASK) ? a_in : mask_q;
			base_q <= (op == dpr_pkg::DPR_OP_LOAD || op == dpr_pkg::DPR_OP_CLR) ? addr_now : base_q;
			if (op == dpr_pkg::DPR_OP_INC) begin
				irq_n_q <= !inc_hits_max;
			end else if (op != dpr_pkg::DPR_OP_HOLD && op != dpr_pkg::DPR_OP_RDBK) begin
				irq_n_q <= 1'b1;
			end
		end
	end

	// Readback drives the address pins from the next edge
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rb_oe_q <= 1'b0;
			rb_val_q <= `DPR_ADDR_ZERO;
		end else begin
			rb_oe_q <= op == dpr_pkg::DPR_OP_RDBK;
			rb_val_q <= sel ? addr_q : mask_q;
		end
	end

	assign wrap_irq_n = irq_n_q;
	assign rb_oe = rb_oe_q;
	assign rb_val = rb_val_q;

	default clocking dpr_cb @(posedge clk); endclocking
	default disable iff (!resetn);

	load_addr_a: assert property (op == dpr_pkg::DPR_OP_LOAD |=> addr_q == $past(a_in)) else $error("load lost");
	clear_addr_a: assert property (!clr_n |-> addr_now == 18'h00000 ##1 addr_q == 18'h00000) else $error("clear failed");
	retransmit_a: assert property (op == dpr_pkg::DPR_OP_INC && at_max |=>
		(addr_q & mask_q) == (base_q & mask_q)) else $error("no retransmit");
	wrap_irq_a: assert property (op == dpr_pkg::DPR_OP_INC && inc_hits_max |=> !wrap_irq_n) else $error("wrap irq");
	readback_sel_a: assert property (op == dpr_pkg::DPR_OP_RDBK |=>
		rb_oe && rb_val == ($past(sel) ? $past(addr_q) : $past(mask_q))) else $error("readback");
endmodule : dpr_addr_ctr

//--- hw/dpr_ports.sv
// Synchronous dual-port memory with burst counters and mailbox flags
// Functional notes
// - Internal select is active while low enable is low and high enable is high.
// - A read sampled at one edge drives data after the next edge only.
// - Output enable gates data pins at once; all else is sampled on the clock.
// - Without select, data pins float after the following edge.
// - Strobe and advance low with counter select high load the address each edge.
// - Data pin state follows controls sampled in the previous cycle.
// - A write while the bus is still driven is dropped; it is not retried at the next edge.
// - Counter clear costs no cycle; the access uses the cleared address.
// - Incrementing past the top wraps to the loaded value and repeats.
// - Readback shows the counter or the mask, as the select level says.
// - A same-address write and read collision drives all-zero read data, then repeats the read.
// - The counter wrap interrupt output is always driven.
// - Wrap interrupt goes low when unmasked counter bits reach their maximum.
// - The top address is the right port's mailbox location.
// - Mailbox flag sets on the writer's edge and clears on the reader's edge.
// - Master reset makes outputs inactive and clears the wrap interrupt.
`timescale 1ns/1ns
`include "dpr_regs.svh"
module dpr_ports (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic CHIP_SELECT_ACTIVE_LOW_IN_L,
	input wire logic CHIP_SELECT_ACTIVE_HIGH_IN_L,
	input wire logic READ_NOT_WRITE_L,
	input wire logic OUTPUT_ENABLE_N_L,
	input wire logic ADDRESS_STROBE_N_L,
	input wire logic COUNTER_ADVANCE_N_L,
	input wire logic COUNTER_CLEAR_N_L,
	input wire logic COUNTER_OR_MASK_SELECT_L,
	input wire logic [3:0] BYTE_LANE_ENABLES_N_L,
	input wire logic [17:0] ADDR_IN_L,
	output logic [17:0] ADDR_OUT_L,
	output logic ADDR_OE_L,
	input wire logic [35:0] DQ_IN_L,
	output logic [35:0] DQ_OUT_L,
	output logic DQ_OE_L,
	output logic COUNTER_WRAP_IRQ_N_L,
	output logic MAILBOX_IRQ_N_L,
	input wire logic CHIP_SELECT_ACTIVE_LOW_IN_R,
	input wire logic CHIP_SELECT_ACTIVE_HIGH_IN_R,
	input wire logic READ_NOT_WRITE_R,
	input wire logic OUTPUT_ENABLE_N_R,
	input wire logic ADDRESS_STROBE_N_R,
	input wire logic COUNTER_ADVANCE_N_R,
	input wire logic COUNTER_CLEAR_N_R,
	input wire logic COUNTER_OR_MASK_SELECT_R,
	input wire logic [3:0] BYTE_LANE_ENABLES_N_R,
	input wire logic [17:0] ADDR_IN_R,
	output logic [17:0] ADDR_OUT_R,
	output logic ADDR_OE_R,
	input wire logic [35:0] DQ_IN_R,
	output logic [35:0] DQ_OUT_R,
	output logic DQ_OE_R,
	output logic COUNTER_WRAP_IRQ_N_R,
	output logic MAILBOX_IRQ_N_R
);
	// Mailbox location owned by a port
	function automatic logic [17:0] dpr_mbox(input int p);
		return (p == 1) ? `DPR_MBOX_R : `DPR_MBOX_L;
	endfunction : dpr_mbox

	logic [1:0] ce_lo_n;
	logic [1:0] ce_hi;
	logic [1:0] rnw;
	logic [1:0] oe_n;
	logic [1:0] ads_n;
	logic [1:0] adv_n;
	logic [1:0] clr_n;
	logic [1:0] msel;
	logic [3:0] be_n [2];
	logic [17:0] a_in [2];
	logic [35:0] dq_in [2];
	logic [17:0] addr_now [2];
	logic [35:0] rd_word [2];
	logic [35:0] dq_out [2];
	logic [17:0] a_out [2];
	logic [1:0] a_oe;
	logic [1:0] wrap_n;
	logic [1:0] cs;
	logic [1:0] be_any;
	logic [1:0] rd_req;
	logic [1:0] wr_req;
	logic [1:0] wr_ok;
	logic [1:0] den;
	logic [1:0] dq_drv;
	logic [1:0] mb_flag;
	logic [8:0] mem [0:3][0:`DPR_DEPTH-1];

	// Left port pins into the port arrays
	assign ce_lo_n[0] = CHIP_SELECT_ACTIVE_LOW_IN_L;
	assign ce_hi[0] = CHIP_SELECT_ACTIVE_HIGH_IN_L;
	assign rnw[0] = READ_NOT_WRITE_L;
	assign oe_n[0] = OUTPUT_ENABLE_N_L;
	assign ads_n[0] = ADDRESS_STROBE_N_L;
	assign adv_n[0] = COUNTER_ADVANCE_N_L;
	assign clr_n[0] = COUNTER_CLEAR_N_L;
	assign msel[0] = COUNTER_OR_MASK_SELECT_L;
	assign be_n[0] = BYTE_LANE_ENABLES_N_L;
	assign a_in[0] = ADDR_IN_L;
	assign dq_in[0] = DQ_IN_L;

	// Right port pins into the port arrays
	assign ce_lo_n[1] = CHIP_SELECT_ACTIVE_LOW_IN_R;
	assign ce_hi[1] = CHIP_SELECT_ACTIVE_HIGH_IN_R;
	assign rnw[1] = READ_NOT_WRITE_R;
	assign oe_n[1] = OUTPUT_ENABLE_N_R;
	assign ads_n[1] = ADDRESS_STROBE_N_R;
	assign adv_n[1] = COUNTER_ADVANCE_N_R;
	assign clr_n[1] = COUNTER_CLEAR_N_R;
	assign msel[1] = COUNTER_OR_MASK_SELECT_R;
	assign be_n[1] = BYTE_LANE_ENABLES_N_R;
	assign a_in[1] = ADDR_IN_R;
	assign dq_in[1] = DQ_IN_R;

	// Port outputs
	assign ADDR_OUT_L = a_out[0];
	assign ADDR_OE_L = a_oe[0];
	assign DQ_OUT_L = dq_out[0];
	assign DQ_OE_L = dq_drv[0];
	assign COUNTER_WRAP_IRQ_N_L = wrap_n[0];
	assign MAILBOX_IRQ_N_L = !mb_flag[0];
	assign ADDR_OUT_R = a_out[1];
	assign ADDR_OE_R = a_oe[1];
	assign DQ_OUT_R = dq_out[1];
	assign DQ_OE_R = dq_drv[1];
	assign COUNTER_WRAP_IRQ_N_R = wrap_n[1];
	assign MAILBOX_IRQ_N_R = !mb_flag[1];

	// Shared array, byte lanes written independently; right port wins a same-lane tie
	always_ff @(posedge CLK) begin
		for (int p = 0; p < 2; p++) begin
			for (int l = 0; l < `DPR_LANES; l++) begin
				if (wr_ok[p] && !be_n[p][l]) begin
					mem[l][addr_now[p]] <= dq_in[p][l*`DPR_LANE_W +: `DPR_LANE_W];
				end
			end
		end
	end

	for (genvar p = 0; p < 2; p++) begin : g_port
		localparam int Q = 1 - p;
		logic rd_q;
		logic coll_q;
		logic retry_q;
		logic den_q;
		logic mb_q;
		logic [17:0] raddr_q;
		logic [17:0] retry_addr_q;
		logic [35:0] dout_q;
		logic coll;
		logic mb_set;
		logic mb_clr;
		logic [17:0] sel_addr;

		dpr_addr_ctr u_ctr (
			.clk(CLK),
			.resetn(RESETN),
			.ads_n(ads_n[p]),
			.adv_n(adv_n[p]),
			.clr_n(clr_n[p]),
			.sel(msel[p]),
			.a_in(a_in[p]),
			.addr_now(addr_now[p]),
			.wrap_irq_n(wrap_n[p]),
			.rb_oe(a_oe[p]),
			.rb_val(a_out[p])
		);

		// Select and request decode for this cycle
		assign cs[p] = !ce_lo_n[p] && ce_hi[p];
		assign be_any[p] = !(&be_n[p]);
		assign rd_req[p] = cs[p] && rnw[p];
		assign wr_req[p] = cs[p] && !rnw[p] && be_any[p];
		assign dq_drv[p] = den[p] && !oe_n[p];
		assign wr_ok[p] = wr_req[p] && !dq_drv[p];
		assign coll = rd_req[p] && wr_ok[Q] && (addr_now[Q] == addr_now[p]);

		// Mailbox: other port writes it, this port reads it back
		assign mb_set = wr_ok[Q] && (addr_now[Q] == dpr_mbox(p));
		assign mb_clr = rd_req[p] && be_any[p] && (addr_now[p] == dpr_mbox(p));

		// Lane-wise read of the word for the output stage
		assign sel_addr = rd_q ? raddr_q : retry_addr_q;
		for (genvar l = 0; l < `DPR_LANES; l++) begin : g_lane
			assign rd_word[p][l*`DPR_LANE_W +: `DPR_LANE_W] = mem[l][sel_addr];
		end

		// Sample stage: controls of this cycle decide the pins two cycles later
		always_ff @(posedge CLK or negedge RESETN) begin
			if (!RESETN) begin
				rd_q <= 1'b0;
				coll_q <= 1'b0;
				raddr_q <= `DPR_ADDR_ZERO;
			end else begin
				rd_q <= rd_req[p];
				coll_q <= coll;
				raddr_q <= addr_now[p];
			end
		end

		// Output stage: drive after the edge that follows the sample
		always_ff @(posedge CLK or negedge RESETN) begin
			if (!RESETN) begin
				den_q <= 1'b0;
				dout_q <= `DPR_COLL_DATA;
				retry_q <= 1'b0;
				retry_addr_q <= `DPR_ADDR_ZERO;
			end else begin
				den_q <= rd_q || retry_q;
				dout_q <= (rd_q && coll_q) ? `DPR_COLL_DATA : rd_word[p];
				retry_q <= rd_q && coll_q;
				retry_addr_q <= raddr_q;
			end
		end

		// Mailbox flag, set beats clear
		always_ff @(posedge CLK or negedge RESETN) begin
			if (!RESETN) begin
				mb_q <= 1'b0;
			end else begin
				mb_q <= mb_set || (mb_q && !mb_clr);
			end
		end

		assign den[p] = den_q;
		assign dq_out[p] = dout_q;
		assign mb_flag[p] = mb_q;
	end

	default clocking dpr_cb @(posedge CLK); endclocking
	default disable iff (!RESETN);

	read_latency_a: assert property (rd_req[0] |-> ##2 den[0]) else $error("left read not driven");
	read_select_a: assert property ((!CHIP_SELECT_ACTIVE_LOW_IN_R && CHIP_SELECT_ACTIVE_HIGH_IN_R && READ_NOT_WRITE_R)
		|-> ##2 den[1]) else $error("right select decode");
	tristate_after_a: assert property (!rd_req[1] [*3] |-> ##1 !DQ_OE_R) else $error("right bus not released");
	oe_async_a: assert property (OUTPUT_ENABLE_N_L |-> !DQ_OE_L) else $error("left drives with oe high");
	prev_cycle_a: assert property (DQ_OE_L |-> $past(g_port[0].rd_q) || $past(g_port[0].retry_q))
		else $error("left drive without cause");
	write_noop_a: assert property (wr_req[0] && DQ_OE_L && !wr_ok[1] |=>
		mem[0][$past(addr_now[0])] == $past(mem[0][addr_now[0]])) else $error("write during drive");
	collide_retry_a: assert property (g_port[1].rd_q && g_port[1].coll_q |=> DQ_OUT_R == 36'h000000000 ##1 den[1])
		else $error("collision retry");
	mbox_set_a: assert property (wr_ok[0] && addr_now[0] == 18'h3FFFF |=> !MAILBOX_IRQ_N_R)
		else $error("mailbox not set");
	mbox_clear_a: assert property (rd_req[1] && be_any[1] && addr_now[1] == 18'h3FFFF && !wr_ok[0]
		|=> MAILBOX_IRQ_N_R) else $error("mailbox not cleared");
	reset_out_a: assert property (@(posedge CLK) disable iff (1'b0) !RESETN |-> !DQ_OE_L && !DQ_OE_R && COUNTER_WRAP_IRQ_N_L
		&& MAILBOX_IRQ_N_R && !ADDR_OE_L) else $error("reset outputs");
endmodule : dpr_ports

//--- verif/dpr_host_addr.sv
// Host side of one port's address pins, stepping off them around readback
`timescale 1ns/1ns
module dpr_host_addr (
	input wire logic clk,
	input wire logic [17:0] host_a,
	input wire logic dev_oe,
	input wire logic [17:0] dev_a,
	output logic [17:0] pin_a
);
	logic hold_q = 1'b0;
	logic [17:0] last_q = 18'h00000;
	// Host waits one cycle after the device lets go before driving again
	always_ff @(posedge clk) begin
		hold_q <= dev_oe;
		last_q <= pin_a;
	end
	// Undriven pins show the inverse of their last level
	assign pin_a = dev_oe ? dev_a : (hold_q ? ~last_q : host_a);
endmodule : dpr_host_addr

//--- verif/testbench.sv
// Self-checking bench for the dual-port memory port logic
`timescale 1ns/1ns
module testbench;
	localparam logic [7:0] c_idl = 8'h5F, c_rd = 8'h33, c_wr = 8'h23, c_inc = 8'h3B, c_clr = 8'h3D;
	localparam logic [7:0] c_msk = 8'h52, c_rbm = 8'h56, c_rbc = 8'h57, c_oeo = 8'hDF;
	logic clk = 1'b0;
	logic rstn = 1'b1;
	integer seed = 36333;
	integer failures = 0;
	integer samples_checked = 0;
	logic [7:0] cw [2] = '{8'h5F, 8'h5F};
	logic [17:0] ad [2] = '{default: 18'h00000};
	logic [35:0] dd [2] = '{default: 36'h000000000};
	logic [3:0] bw [2] = '{default: 4'hF};
	logic oen [2], cs0 [2], cs1 [2], rnw [2], address_strobe_n [2], adv [2], clr [2], sel [2];
	logic aoe [2], dqoe [2], wirq [2], mbn [2];
	logic [3:0] be [2];
	logic [17:0] ha [2], pa [2], ao [2];
	logic [35:0] din [2], dq [2];
	logic [35:0] mem [int];
	logic [35:0] q [2][$];
	always #4 clk = ~clk;
	dpr_ports i_dut (.CLK(clk), .RESETN(rstn),
		.CHIP_SELECT_ACTIVE_LOW_IN_L(cs0[0]), .CHIP_SELECT_ACTIVE_HIGH_IN_L(cs1[0]), .READ_NOT_WRITE_L(rnw[0]),
		.OUTPUT_ENABLE_N_L(oen[0]), .ADDRESS_STROBE_N_L(address_strobe_n[0]), .COUNTER_ADVANCE_N_L(adv[0]),
		.COUNTER_CLEAR_N_L(clr[0]), .COUNTER_OR_MASK_SELECT_L(sel[0]), .BYTE_LANE_ENABLES_N_L(be[0]),
		.ADDR_IN_L(pa[0]), .ADDR_OUT_L(ao[0]), .ADDR_OE_L(aoe[0]), .DQ_IN_L(din[0]), .DQ_OUT_L(dq[0]),
		.DQ_OE_L(dqoe[0]), .COUNTER_WRAP_IRQ_N_L(wirq[0]), .MAILBOX_IRQ_N_L(mbn[0]),
		.CHIP_SELECT_ACTIVE_LOW_IN_R(cs0[1]), .CHIP_SELECT_ACTIVE_HIGH_IN_R(cs1[1]), .READ_NOT_WRITE_R(rnw[1]),
		.OUTPUT_ENABLE_N_R(oen[1]), .ADDRESS_STROBE_N_R(address_strobe_n[1]), .COUNTER_ADVANCE_N_R(adv[1]),
		.COUNTER_CLEAR_N_R(clr[1]), .COUNTER_OR_MASK_SELECT_R(sel[1]), .BYTE_LANE_ENABLES_N_R(be[1]),
		.ADDR_IN_R(pa[1]), .ADDR_OUT_R(ao[1]), .ADDR_OE_R(aoe[1]), .DQ_IN_R(din[1]), .DQ_OUT_R(dq[1]),
		.DQ_OE_R(dqoe[1]), .COUNTER_WRAP_IRQ_N_R(wirq[1]), .MAILBOX_IRQ_N_R(mbn[1]));
	dpr_host_addr i_hal (.clk(clk), .host_a(ha[0]), .dev_oe(aoe[0]), .dev_a(ao[0]), .pin_a(pa[0]));
	dpr_host_addr i_har (.clk(clk), .host_a(ha[1]), .dev_oe(aoe[1]), .dev_a(ao[1]), .pin_a(pa[1]));
	task rep(input logic [35:0] e, input logic [35:0] g);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : rep
	task chk_dq(input logic [35:0] e, input logic [35:0] g);
		rep(e, g);
	endtask : chk_dq
	task chk_ad(input logic [17:0] e, input logic [17:0] g);
		rep({18'h00000, e}, {18'h00000, g});
	endtask : chk_ad
	task chk_fl(input logic e, input logic g);
		rep({35'h000000000, e}, {35'h000000000, g});
	endtask : chk_fl
	function logic [35:0] mrg(input logic [35:0] o, input logic [35:0] n, input logic [3:0] b);
		for (int l = 0; l < 4; l++) begin
			if (!b[l]) o[9 * l +: 9] = n[9 * l +: 9];
		end
		return o;
	endfunction : mrg
	function logic [35:0] rnd();
		return 36'({$random(seed), $random(seed)});
	endfunction : rnd
	function logic [17:0] ta(input int i);
		return i ? 18'h00010 + 18'(i) : 18'h00000;
	endfunction : ta
	// Pins take the queued control word at the rising edge, then fall back to idle
	task apply;
		for (int p = 0; p < 2; p++) begin
			{oen[p], cs0[p], cs1[p], rnw[p], address_strobe_n[p], adv[p], clr[p], sel[p]} <= cw[p];
			ha[p] <= ad[p];
			din[p] <= dd[p];
			be[p] <= bw[p];
			cw[p] = c_idl;
			bw[p] = 4'hF;
		end
	endtask : apply
	initial apply;
	always @(posedge clk) apply;
	task nxt;
		@(negedge clk);
	endtask : nxt
	task wr(input int p, input logic [17:0] a, input logic [35:0] d, input logic [3:0] b, input bit keep);
		cw[p] = c_wr;
		ad[p] = a;
		dd[p] = d;
		bw[p] = b;
		if (keep) mem[a] = mrg(mem[a], d, b);
	endtask : wr
	task rd(input int p, input logic [7:0] w, input logic [17:0] a, input logic [17:0] e);
		cw[p] = w;
		ad[p] = a;
		bw[p] = 4'h0;
		q[p].push_back(mem[e]);
	endtask : rd
	task done(input string s);
		$display("test %s finished", s);
	endtask : done
	task wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrap_up
	// Each driven data beat is matched against the oldest expected value
	always @(negedge clk) begin
		if (rstn) begin
			for (int p = 0; p < 2; p++) begin
				if (dqoe[p] === 1'b1) chk_dq(q[p].size() ? q[p].pop_front() : 36'hX, dq[p]);
			end
		end
	end
	// Main sequence
	initial begin
		rstn <= 1'b0; // Falling edge at time zero fires the async reset
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		nxt;
		for (int p = 0; p < 2; p++) begin
			chk_fl(1'b0, dqoe[p]);
			chk_fl(1'b1, wirq[p]);
		end
		done("reset");
		for (int i = 0; i < 10; i++) begin
			wr(0, ta(i % 5), rnd(), i < 5 ? 4'h0 : 4'($random(seed)), 1'b1);
			nxt;
		end
		for (int i = 0; i < 5; i++) begin
			rd(1, c_rd, ta(i), ta(i));
			nxt;
		end
		done("write read");
		for (int i = 0; i < 4; i++) begin
			cw[0] = (c_rd & 8'h9F) | 8'(i << 5);
			ad[0] = 18'h00011;
			if (i == 1) q[0].push_back(mem[18'h00011]);
			nxt;
		end
		done("select");
		cw[0] = c_rd;
		ad[0] = 18'h00012;
		repeat (2) nxt;
		cw[0] = c_oeo;
		repeat (2) nxt;
		rd(0, c_rd, 18'h00013, 18'h00013);
		repeat (2) nxt;
		wr(0, 18'h00013, rnd(), 4'h0, 1'b0);
		nxt;
		rd(0, c_rd, 18'h00013, 18'h00013);
		repeat (3) nxt;
		wr(0, 18'h00013, rnd(), 4'h0, 1'b1);
		nxt;
		rd(0, c_rd, 18'h00013, 18'h00013);
		repeat (4) nxt;
		done("turnaround");
		q[1].push_back(36'h000000000);
		wr(0, 18'h00014, rnd(), 4'h0, 1'b1);
		rd(1, c_rd, 18'h00014, 18'h00014);
		repeat (5) nxt;
		done("collision");
		rd(0, c_clr, 18'h0ABCD, 18'h00000);
		nxt;
		cw[0] = c_msk;
		ad[0] = 18'h00003;
		nxt;
		for (int k = 0; k < 6; k++) begin
			rd(0, k ? c_inc : c_rd, 18'h00011, 18'h00011 + 18'(k % 3));
			nxt;
			if (k > 0) chk_fl((k - 1) % 3 != 2, wirq[0]);
		end
		cw[0] = c_rbm;
		nxt;
		chk_fl(1'b0, wirq[0]);
		cw[0] = c_rbc;
		nxt;
		chk_ad(18'h00003, ao[0]);
		chk_fl(1'b1, aoe[0]);
		nxt;
		chk_ad(18'h00013, ao[0]);
		done("counter");
		@(posedge clk);
		rstn <= 1'b0;
		@(posedge clk);
		rstn <= 1'b1;
		nxt;
		chk_fl(1'b1, wirq[0]);
		chk_fl(1'b0, aoe[0]);
		chk_fl(1'b0, aoe[1]);
		cw[1] = c_rbm;
		repeat (2) nxt;
		chk_ad(18'h3FFFF, ao[1]);
		chk_fl(1'b1, aoe[1]);
		repeat (2) nxt;
		chk_fl(1'b0, aoe[1]);
		done("master clear");
		for (int p = 0; p < 2; p++) begin
			wr(p, p ? 18'h3FFFE : 18'h3FFFF, rnd(), 4'h0, 1'b1);
			repeat (2) nxt;
			chk_fl(1'b0, mbn[1 - p]);
			rd(1 - p, c_rd, p ? 18'h3FFFE : 18'h3FFFF, p ? 18'h3FFFE : 18'h3FFFF);
			repeat (2) nxt;
			chk_fl(1'b1, mbn[1 - p]);
			nxt;
		end
		repeat (3) nxt;
		chk_fl(1'b1, q[0].size() == 0 && q[1].size() == 0);
		done("mailbox");
		wrap_up;
	end
	// Cuts a hang short
	initial begin
		#20000;
		failures++;
		wrap_up;
	end
endmodule : testbench
